// [hdl/hub_cfg_pkg.sv]
// Behaviour
// - reserved upper bits of charge and removable registers read zero, ignore writes
// - a charge-enable bit set enables charging features on its port, clear disables
// - charge-enable bit n controls downstream port n+1
// - charge-enable default is taken from the power/charge strap pins at reset release
// - in serial-config mode the loader or host may overwrite the charge-enable field
// - override bit 7 makes the removable field writable; clear makes it read-only
// - one write setting the override also stores the removable bits in that write
// - removable bit reads one for removable, zero for fixed, bit n is port n+1
// - with override clear, removable field reads as inverse of one-time non-removable bits
// - port-in-service bit one enables, zero disables its port; all four reset to one
// - port-in-service bit n controls downstream port n+1
// - second config register resets bits 7,6,4,3,2,0 to zero; 5 and 1 from straps
// - bit 5 samples the polarity strap at release: zero low-active, one high-active
// - bit 1 samples the auto-charge strap at release: zero enables automatic mode
package hub_cfg_pkg;
   // register offsets
   localparam logic [7:0] ADDR_CHARGE = 8'h06;
   localparam logic [7:0] ADDR_REMOVABLE = 8'h07;
   localparam logic [7:0] ADDR_IN_SERVICE = 8'h08;
   localparam logic [7:0] ADDR_DEV_CFG2 = 8'h0A;
   // field positions
   localparam int PORT_LSB = 0;
   localparam int PORT_MSB = 3;
   localparam int OVERRIDE_BIT = 7;
   localparam int CFG2_CUSTOM_BC_BIT = 6;
   localparam int CFG2_POL_BIT = 5;
   localparam int CFG2_HICUR_BIT = 4;
   localparam int CFG2_ATTACH_BIT = 3;
   localparam int CFG2_ECR_BIT = 2;
   localparam int CFG2_AUTO_BIT = 1;
   // reset values
   localparam logic [3:0] CHARGE_RESET = 4'h0;
   localparam logic [3:0] REMOVABLE_RESET = 4'h0;
   localparam logic OVERRIDE_RESET = 1'b0;
   localparam logic [3:0] IN_SERVICE_RESET = 4'hF;
   localparam logic [7:0] CFG2_RESET = 8'h00;
   // strap synchroniser depth, capture happens once it is filled
   localparam logic [1:0] STRAP_SYNC_STAGES = 2'h2;

   // one register access from the serial loader or bus host
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } cfg_req_t;

   // strap levels as seen after synchronisation
   typedef struct packed {
      logic [3:0] charge;
      logic polarity;
      logic auto_n;
   } strap_t;
endpackage

// [hdl/hub_port_config_registers.sv]
`timescale 1ns/1ps
module hub_port_config_registers
   import hub_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register access from loader or bus host
   input wire cfg_req_t req,
   input wire logic serial_cfg_mode,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // strap pins, asynchronous
   input wire strap_t strap_pins,
   // one-time-programmable values, same clock domain
   input wire logic [3:0] otp_non_removable,
   input wire logic otp_high_current,
   input wire logic otp_attach_detect,
   input wire logic otp_ecr_enable,
   // per-port controls, bit n is downstream port n+1
   output logic [3:0] charge_port_enable_bits,
   output logic [3:0] port_removable,
   output logic [3:0] port_in_service,
   // device controls
   output logic power_switch_polarity,
   output logic auto_charge_mode_disable_n,
   output logic high_current_enable,
   output logic attach_detect_enable,
   output logic ecr_enable
);
   strap_t straps;
   logic capture;
   logic removable_override_enable;
   logic [3:0] rmbl_reg;
   logic custom_bc_reg;
   logic hicur_reg;
   logic attach_reg;
   logic ecr_reg;
   logic cfg2_bit1_reg;
   logic [3:0] removable_view;
   logic hicur_view;
   logic attach_view;
   logic [7:0] rd_next;

   // accepted write strobes; writes only land in serial-config mode
   function automatic logic wr_hit(input cfg_req_t r, input logic mode, input logic [7:0] a);
      wr_hit = r.wr && mode && (r.addr == a);
   endfunction

   strap_sampler u_straps (
      .clk(clk),
      .arst_n(arst_n),
      .pins(strap_pins),
      .straps(straps),
      .capture(capture)
   );

   // charge enables: strap load at release wins over a write in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         charge_port_enable_bits <= CHARGE_RESET;
      end else if (capture) begin
         charge_port_enable_bits <= straps.charge;
      end else if (wr_hit(req, serial_cfg_mode, ADDR_CHARGE)) begin
         charge_port_enable_bits <= req.data[PORT_MSB:PORT_LSB];
      end
   end

   // override and removable bits; the override may be set in the same write as the bits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         removable_override_enable <= OVERRIDE_RESET;
         rmbl_reg <= REMOVABLE_RESET;
      end else if (wr_hit(req, serial_cfg_mode, ADDR_REMOVABLE)) begin
         removable_override_enable <= req.data[OVERRIDE_BIT];
         if (req.data[OVERRIDE_BIT]) begin
            rmbl_reg <= req.data[PORT_MSB:PORT_LSB];
         end
         // override clear in the write: field stays read-only and keeps its value
      end
   end

   // port-in-service; the 1-and-3 both-off case is the host's duty, stored as written
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port_in_service <= IN_SERVICE_RESET;
      end else if (wr_hit(req, serial_cfg_mode, ADDR_IN_SERVICE)) begin
         port_in_service <= req.data[PORT_MSB:PORT_LSB];
      end
   end

   // second config register, straps reload bits 5 and 1 at release
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         custom_bc_reg <= CFG2_RESET[CFG2_CUSTOM_BC_BIT];
         power_switch_polarity <= CFG2_RESET[CFG2_POL_BIT];
         hicur_reg <= CFG2_RESET[CFG2_HICUR_BIT];
         attach_reg <= CFG2_RESET[CFG2_ATTACH_BIT];
         ecr_reg <= CFG2_RESET[CFG2_ECR_BIT];
         cfg2_bit1_reg <= CFG2_RESET[CFG2_AUTO_BIT];
      end else if (capture) begin
         power_switch_polarity <= straps.polarity;
         cfg2_bit1_reg <= straps.auto_n;
      end else if (wr_hit(req, serial_cfg_mode, ADDR_DEV_CFG2)) begin
         custom_bc_reg <= req.data[CFG2_CUSTOM_BC_BIT];
         power_switch_polarity <= req.data[CFG2_POL_BIT];
         ecr_reg <= req.data[CFG2_ECR_BIT];
         cfg2_bit1_reg <= req.data[CFG2_AUTO_BIT];
         // like the removable override, custom bit unlocks its fields in the same write
         if (req.data[CFG2_CUSTOM_BC_BIT]) begin
            hicur_reg <= req.data[CFG2_HICUR_BIT];
            attach_reg <= req.data[CFG2_ATTACH_BIT];
         end
      end
   end

   // effective values: locked fields follow the one-time memory
   always_comb begin
      removable_view = removable_override_enable ? rmbl_reg : ~otp_non_removable;
      hicur_view = custom_bc_reg ? hicur_reg : otp_high_current;
      attach_view = custom_bc_reg ? attach_reg : otp_attach_detect;
   end

   // registered control outputs, bit n drives port n+1
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port_removable <= REMOVABLE_RESET;
         high_current_enable <= 1'b0;
         attach_detect_enable <= 1'b0;
         ecr_enable <= 1'b0;
         auto_charge_mode_disable_n <= 1'b0;
      end else begin
         port_removable <= removable_view;
         high_current_enable <= hicur_view;
         attach_detect_enable <= attach_view;
         ecr_enable <= ecr_reg | otp_ecr_enable; // enable reads as or with memory bit
         auto_charge_mode_disable_n <= cfg2_bit1_reg;
      end
   end

   // read mux; reserved bits and unmapped offsets read zero
   always_comb begin
      rd_next = 8'h00;
      unique case (req.addr)
         ADDR_CHARGE: rd_next[PORT_MSB:PORT_LSB] = charge_port_enable_bits;
         ADDR_REMOVABLE: begin
            rd_next[OVERRIDE_BIT] = removable_override_enable;
            rd_next[PORT_MSB:PORT_LSB] = removable_view;
         end
         ADDR_IN_SERVICE: rd_next[PORT_MSB:PORT_LSB] = port_in_service;
         ADDR_DEV_CFG2: begin
            rd_next[CFG2_CUSTOM_BC_BIT] = custom_bc_reg;
            rd_next[CFG2_POL_BIT] = power_switch_polarity;
            rd_next[CFG2_HICUR_BIT] = hicur_view;
            rd_next[CFG2_ATTACH_BIT] = attach_view;
            rd_next[CFG2_ECR_BIT] = ecr_reg | otp_ecr_enable;
            rd_next[CFG2_AUTO_BIT] = cfg2_bit1_reg; // bits 7 and 0 stay zero
         end
         default: rd_next = 8'h00;
      endcase
   end

   // read answer one cycle after the request
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= req.rd;
         if (req.rd) begin
            rd_data <= rd_next;
         end
      end
   end

   // properties sample on the system clock and sleep through reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_resv_charge_zero: assert property (req.rd && req.addr == ADDR_CHARGE |=> rd_valid && rd_data[7:4] == 4'h0)
      else $error("charge reserved bits not zero");
   a_resv_rmbl_zero: assert property (req.rd && req.addr == ADDR_REMOVABLE |=> rd_data[6:4] == 3'h0)
      else $error("removable reserved bits not zero");
   a_charge_write_lands: assert property (wr_hit(req, serial_cfg_mode, ADDR_CHARGE) && !capture
      |=> charge_port_enable_bits == $past(req.data[3:0]))
      else $error("charge write not stored");
   a_charge_strap_load: assert property (capture |=> charge_port_enable_bits == $past(straps.charge))
      else $error("charge strap not loaded");
   a_rmbl_same_write: assert property (wr_hit(req, serial_cfg_mode, ADDR_REMOVABLE) && req.data[7]
      |=> ##1 port_removable == $past(req.data[3:0], 2))
      else $error("override write lost removable bits");
   a_rmbl_locked_write: assert property (wr_hit(req, serial_cfg_mode, ADDR_REMOVABLE) && !req.data[7]
      |=> $stable(rmbl_reg) && !removable_override_enable)
      else $error("locked removable field changed");
   a_rmbl_otp_inverse: assert property (!removable_override_enable && $stable(otp_non_removable) && $past(arst_n)
      |=> port_removable == ~$past(otp_non_removable))
      else $error("removable not inverse of memory");
   a_used_write_lands: assert property (wr_hit(req, serial_cfg_mode, ADDR_IN_SERVICE)
      |=> port_in_service == $past(req.data[3:0]))
      else $error("in-service write not stored");
   a_cfg2_resv_zero: assert property (req.rd && req.addr == ADDR_DEV_CFG2 |=> !rd_data[7] && !rd_data[0])
      else $error("cfg2 reserved bits not zero");
   a_pol_strap_load: assert property (capture |=> power_switch_polarity == $past(straps.polarity))
      else $error("polarity strap not loaded");
   a_auto_strap_load: assert property (capture |=> ##1 auto_charge_mode_disable_n == $past(straps.auto_n, 2))
      else $error("auto strap not loaded");
   a_no_write_off_mode: assert property (req.wr && !serial_cfg_mode && !capture
      |=> $stable(charge_port_enable_bits) && $stable(port_in_service))
      else $error("write outside serial mode took effect");

   // read-back and override checks; a read answers with the value held at its request edge
   a_ovr_write_applied: assert property (wr_hit(req, serial_cfg_mode, ADDR_REMOVABLE) && req.data[7]
      |=> removable_override_enable && rmbl_reg == $past(req.data[3:0]))
      else $error("override write not applied");
   a_rmbl_read_inverse: assert property (req.rd && req.addr == ADDR_REMOVABLE && !removable_override_enable
      |=> rd_data[3:0] == ~$past(otp_non_removable))
      else $error("locked removable read not inverse");
   a_charge_read_map: assert property (req.rd && req.addr == ADDR_CHARGE
      |=> rd_data[3:0] == $past(charge_port_enable_bits))
      else $error("charge read does not match field");
   a_used_read_map: assert property (req.rd && req.addr == ADDR_IN_SERVICE
      |=> rd_data == {4'h0, $past(port_in_service)})
      else $error("in-service read does not match field");
endmodule

// [hdl/strap_sampler.sv]
`timescale 1ns/1ps
// synchronises strap pins and pulses once when the synchronised value is valid after reset release
module strap_sampler
   import hub_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // pins
   input wire strap_t pins,
   // result
   output strap_t straps,
   output logic capture
);
   strap_t sync1_reg;
   strap_t sync2_reg;
   logic [1:0] fill_reg;

   // two-flop synchroniser; stage one feeds only stage two
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
      end
   end

   // wait until stage two holds a pin value, then fire a single capture
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fill_reg <= 2'h0;
         capture <= 1'b0;
      end else begin
         capture <= (fill_reg == STRAP_SYNC_STAGES - 2'h1);
         if (fill_reg != STRAP_SYNC_STAGES) begin
            fill_reg <= fill_reg + 2'h1;
         end
      end
   end

   assign straps = sync2_reg;
endmodule

// [sim/cfg_host_model.sv]
`timescale 1ns/1ps
// bus host on the far side: issues single-byte register reads and writes
module cfg_host_model
   import hub_cfg_pkg::*;
(
   // clock
   input wire logic clk,
   // request side
   output cfg_req_t req,
   // answer side
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   initial req = '0;

   // one write pulse; request launched after an edge, dropped after the taking edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      // a real host never takes ports 1 and 3 out of service together
      if (!(a == ADDR_IN_SERVICE && d[0] == 1'b0 && d[2] == 1'b0)) begin
         @(posedge clk);
         req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
         @(posedge clk);
         req <= '0;
      end
   endtask

   // one read pulse; answer is settled just after the taking edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      ok = rd_valid;
      d = rd_data;
   endtask
endmodule

// [sim/tb_hub_port_config_registers.sv]
`timescale 1ns/1ps
module tb_hub_port_config_registers;
   import hub_cfg_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic serial_cfg_mode = 1'b1;
   strap_t strap_pins = '{charge: 4'h9, polarity: 1'b1, auto_n: 1'b1};
   logic [3:0] otp_non_removable = 4'h3;
   cfg_req_t req;
   logic [7:0] rd_data;
   logic rd_valid;
   logic [3:0] charge_port_enable_bits, port_removable, port_in_service;
   logic power_switch_polarity, auto_charge_mode_disable_n;
   logic high_current_enable, attach_detect_enable, ecr_enable;
   int errors = 0;
   int n_tests = 0;

   // clock, 100 MHz
   initial forever #5 clk = ~clk;

   hub_port_config_registers u_dut (.clk(clk), .arst_n(arst_n), .req(req), .serial_cfg_mode(serial_cfg_mode),
      .rd_data(rd_data), .rd_valid(rd_valid), .strap_pins(strap_pins), .otp_non_removable(otp_non_removable),
      .otp_high_current(1'b0), .otp_attach_detect(1'b0), .otp_ecr_enable(1'b0),
      .charge_port_enable_bits(charge_port_enable_bits), .port_removable(port_removable),
      .port_in_service(port_in_service), .power_switch_polarity(power_switch_polarity),
      .auto_charge_mode_disable_n(auto_charge_mode_disable_n), .high_current_enable(high_current_enable),
      .attach_detect_enable(attach_detect_enable), .ecr_enable(ecr_enable));

   cfg_host_model u_host (.clk(clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));

   task automatic finish_test();
      if (errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // compare of a read answer
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t rd got=%h exp=%h", $time, got, exp);
      end
   endtask

   // compare of a control output
   task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
      end
   endtask

   // read and compare, including the one-cycle valid
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      u_host.read_reg(a, d, ok);
      chk_rd({7'h00, ok}, 8'h01);
      chk_rd(d, exp);
   endtask

   // hang guard, tests need well under 2000 cycles
   initial begin
      #20us;
      errors++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk_pin(charge_port_enable_bits, 4'h9);
      chk_pin({3'h0, power_switch_polarity}, 4'h1);
      chk_pin({3'h0, auto_charge_mode_disable_n}, 4'h1);
      chk_pin(port_in_service, 4'hF);
      chk_pin(port_removable, 4'hC);
      rd_chk(ADDR_CHARGE, 8'h09);
      rd_chk(ADDR_IN_SERVICE, 8'h0F);
      rd_chk(ADDR_DEV_CFG2, 8'h22);
      rd_chk(ADDR_REMOVABLE, 8'h0C);
      rd_chk(8'h09, 8'h00);
      // locked field: bits in a write without override are dropped
      u_host.write_reg(ADDR_REMOVABLE, 8'h75);
      rd_chk(ADDR_REMOVABLE, 8'h0C);
      u_host.write_reg(ADDR_REMOVABLE, 8'hFA);
      rd_chk(ADDR_REMOVABLE, 8'h8A);
      chk_pin(port_removable, 4'hA);
      u_host.write_reg(ADDR_REMOVABLE, 8'h05);
      rd_chk(ADDR_REMOVABLE, 8'h0C);
      chk_pin(port_removable, 4'hC);
      // walk a single charge bit across the ports, reserved bits set
      for (int n = 0; n < 4; n++) begin
         u_host.write_reg(ADDR_CHARGE, 8'hF0 | (8'h01 << n));
         rd_chk(ADDR_CHARGE, 8'h01 << n);
         chk_pin(charge_port_enable_bits, 4'h1 << n);
      end
      // outside serial-config mode writes are ignored
      @(posedge clk);
      serial_cfg_mode <= 1'b0;
      u_host.write_reg(ADDR_CHARGE, 8'h0F);
      rd_chk(ADDR_CHARGE, 8'h08);
      @(posedge clk);
      serial_cfg_mode <= 1'b1;
      u_host.write_reg(ADDR_CHARGE, 8'h0F);
      // the field updates on the taking edge; look once it has settled
      #1;
      chk_pin(charge_port_enable_bits, 4'hF);
      u_host.write_reg(ADDR_IN_SERVICE, 8'hF5);
      rd_chk(ADDR_IN_SERVICE, 8'h05);
      chk_pin(port_in_service, 4'h5);
      // second config register: custom bit unlocks 4 and 3 in the same write, 7 and 0 stay zero
      u_host.write_reg(ADDR_DEV_CFG2, 8'hFF);
      rd_chk(ADDR_DEV_CFG2, 8'h7E);
      chk_pin({1'b0, high_current_enable, attach_detect_enable, ecr_enable}, 4'h7);
      // second reset with new straps
      @(posedge clk);
      strap_pins <= '{charge: 4'h6, polarity: 1'b0, auto_n: 1'b0};
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk_pin(port_in_service, 4'hF);
      @(posedge clk);
      arst_n <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk_pin(charge_port_enable_bits, 4'h6);
      chk_pin({3'h0, power_switch_polarity}, 4'h0);
      chk_pin({3'h0, auto_charge_mode_disable_n}, 4'h0);
      chk_pin({1'b0, high_current_enable, attach_detect_enable, ecr_enable}, 4'h0);
      rd_chk(ADDR_DEV_CFG2, 8'h00);
      finish_test();
   end
endmodule
